// ### dv/icf_dev_model.sv
// Behavioural transceiver model seen from its logic pins.
`timescale 1ns/1ps
`default_nettype none
module icf_dev_model #(parameter int TDT = 400, parameter int ALIVE_GAP = 50) (
  input wire logic core_clk,
  input wire icf_pkg::icf_pins_type pins,
  input wire logic hot,
  output logic rxd_pin,
  output logic aux_out,
  output logic keep_alive
);
  int low_cnt = 0;
  int alive_cnt = 0;
  logic tripped = 1'b0;
  logic tx_in;
  assign tx_in = (pins.txd !== 1'b0) | pins.listen_only | pins.low_power_request;
  always @(posedge core_clk) begin
    low_cnt <= tx_in ? 0 : low_cnt + 1;
    if (tx_in) tripped <= 1'b0;
    else if (low_cnt >= TDT) tripped <= 1'b1;
    if (!pins.low_power_request) aux_out <= pins.aux_pin;
    if (!pins.low_power_request || alive_cnt == ALIVE_GAP - 1) alive_cnt <= 0;
    else alive_cnt <= alive_cnt + 1;
  end
  assign keep_alive = pins.low_power_request && (alive_cnt == ALIVE_GAP - 1);
  assign rxd_pin = tx_in | tripped | hot;
endmodule : icf_dev_model
`default_nettype wire

// ### dv/icf_host_sva.sv
// Checker on the host controller ports.
`timescale 1ns/1ps
`default_nettype none
module icf_host_sva #(parameter int DOM_LIMIT = 200) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic can_tx_bit,
  input wire logic standby_req,
  input wire icf_pkg::icf_pins_type pins,
  input wire icf_pkg::icf_status_type status
);
  logic [15:0] low_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) low_q <= 16'h0;
    else low_q <= pins.txd ? 16'h0 : low_q + 16'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_aux_bit_len: assert property ($changed(pins.aux_pin) |=> $stable(pins.aux_pin) [*7])
    else $error("aux bit too short");
  chk_rearm_txd_high: assert property (status.rearm_active |-> pins.txd)
    else $error("txd low while rearming");
  chk_dom_run_bound: assert property (low_q <= DOM_LIMIT + 1)
    else $error("txd low past limit");
  chk_txd_follows: assert property (!$past(pins.low_power_request) && !status.rearm_active
    && !$past(status.rearm_active) |-> pins.txd == $past(can_tx_bit))
    else $error("txd does not follow the bit");
  chk_lpr_follows: assert property (pins.low_power_request == $past(standby_req))
    else $error("standby pin does not follow the request");
  chk_standby_txd_high: assert property (pins.low_power_request |=> pins.txd)
    else $error("txd low during standby");
endmodule : icf_host_sva
bind icf_host icf_host_sva #(.DOM_LIMIT(DOM_LIMIT)) u_sva (.core_clk(core_clk), .rst_n(rst_n),
  .can_tx_bit(can_tx_bit), .standby_req(standby_req), .pins(pins), .status(status));
`default_nettype wire

// ### dv/icf_host_tb_top.sv
// Self-checking bench for the host controller against a transceiver model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module icf_host_tb_top;
  localparam int AUXB = 8;
  logic core_clk = 1'b0, rst_n = 1'b0, can_tx_bit = 1'b1, standby_req = 1'b0, hot = 1'b0;
  logic listen_req = 1'b0, status_clr = 1'b0, aux_valid = 1'b0, b, last;
  logic [7:0] aux_data = 8'h00, e;
  logic can_rx_bit, aux_ready, rxd_pin, aux_out, keep_alive;
  logic [8:0] got;
  icf_pkg::icf_pins_type pins;
  icf_pkg::icf_status_type status;
  int errors = 0, samples_checked = 0, run;
  int alive_seen = 0;
  logic [7:0] exp_q[$];
  icf_host #(.DOM_LIMIT(200), .REARM_CYC(16), .AUX_BIT(AUXB)) dut (.core_clk(core_clk),
    .rst_n(rst_n), .can_tx_bit(can_tx_bit), .can_rx_bit(can_rx_bit), .standby_req(standby_req),
    .listen_req(listen_req), .status_clr(status_clr), .aux_data(aux_data),
    .aux_valid(aux_valid), .aux_ready(aux_ready), .rxd_pin(rxd_pin), .pins(pins), .status(status));
  icf_dev_model u_dev (.core_clk(core_clk), .pins(pins), .hot(hot), .rxd_pin(rxd_pin),
    .aux_out(aux_out), .keep_alive(keep_alive));
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (keep_alive === 1'b1) alive_seen++;
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial forever begin
    @(negedge pins.aux_pin);
    cyc(AUXB / 2);
    for (int i = 0; i < 9; i++) begin
      cyc(AUXB);
      got[8 - i] = pins.aux_pin;
    end
    e = exp_q.pop_front();
    `CHK("aux byte", e, got[8:1])
    `CHK("aux stop", 1'b1, got[0])
  end
  initial begin
    #(40 * 20000);
    errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(31));
    cyc(8);
    rst_n = 1'b1;
    aux_valid = 1'b1;
    for (int i = 0; i < 6; i++) begin
      aux_data = 8'($urandom);
      exp_q.push_back(aux_data);
      while (aux_ready !== 1'b1) cyc(1);
      cyc(1);
      if (i == 4) `CHK("fifo full", 1'b0, aux_ready)
    end
    aux_valid = 1'b0;
    while (exp_q.size() != 0) cyc(1);
    standby_req = 1'b1;
    cyc(2);
    aux_valid = 1'b1;
    exp_q.push_back(aux_data);
    cyc(1);
    aux_valid = 1'b0;
    cyc(100);
    `CHK("aux held", 1'b1, pins.aux_pin)
    `CHK("model aux", 1'b1, aux_out)
    `CHK("keep alive", 1'b1, alive_seen != 0)
    standby_req = 1'b0;
    while (exp_q.size() != 0) cyc(1);
    run = 0;
    last = 1'b1;
    for (int i = 0; i < 60; i++) begin
      b = (i >= 40 && i < 46) ? 1'b0 : (run >= 5 ? !last : 1'($urandom));
      run = (b == last) ? run + 1 : 1;
      last = b;
      can_tx_bit = b;
      cyc(6);
      `CHK("rx bit", b, can_rx_bit)
    end
    `CHK("no timeout", 1'b0, status.dom_timeout_seen)
    `CHK("no long run", 1'b0, status.dom_run_long)
    can_tx_bit = 1'b0;
    cyc(190);
    `CHK("long run", 1'b1, status.dom_run_long)
    `CHK("no early timeout", 1'b0, status.dom_timeout_seen)
    cyc(15);
    `CHK("dom timeout", 1'b1, status.dom_timeout_seen)
    `CHK("rearm txd", 1'b1, pins.txd)
    can_tx_bit = 1'b1;
    cyc(30);
    `CHK("rearm end", 1'b0, status.rearm_active)
    listen_req = 1'b1;
    can_tx_bit = 1'b0;
    cyc(20);
    `CHK("listen rx", 1'b1, can_rx_bit)
    `CHK("listen pin", 1'b1, pins.listen_only)
    listen_req = 1'b0;
    hot = 1'b1;
    cyc(20);
    `CHK("driver off", 1'b1, status.driver_off_seen)
    `CHK("rx real", 1'b1, can_rx_bit)
    hot = 1'b0;
    cyc(10);
    `CHK("rx cooled", 1'b0, can_rx_bit)
    can_tx_bit = 1'b1;
    status_clr = 1'b1;
    cyc(1);
    status_clr = 1'b0;
    cyc(1);
    `CHK("cleared", 2'b00, {status.dom_timeout_seen, status.driver_off_seen})
    tally_and_finish();
  end
endmodule : icf_host_tb_top
`default_nettype wire

// ### rtl/icf_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module icf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] count;
  } icf_fifo_state_type;

  icf_fifo_state_type s_q;
  icf_fifo_state_type s_d;
  logic push;
  logic pop;

  assign in_ready = (s_q.count != CW'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data = s_q.mem[s_q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
    end
    if (push && !pop) begin
      s_d.count = s_q.count + 1'b1;
    end else if (pop && !push) begin
      s_d.count = s_q.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : icf_fifo
`default_nettype wire

// ### rtl/icf_host.sv
// Host controller that drives the isolated CAN transceiver pins and its auxiliary channel.
`timescale 1ns/1ps
`default_nettype none
module icf_host #(
  parameter int DOM_LIMIT = icf_pkg::DOM_LIMIT_CYC,
  parameter int REARM_CYC = icf_pkg::CAN_MAX_BIT_CYC,
  parameter int AUX_BIT = icf_pkg::AUX_BIT_CYC,
  parameter int AUX_W = icf_pkg::AUX_WIDTH,
  parameter int DEPTH = icf_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic can_tx_bit,
  output logic can_rx_bit,
  input wire logic standby_req,
  input wire logic listen_req,
  input wire logic status_clr,
  input wire logic [AUX_W-1:0] aux_data,
  input wire logic aux_valid,
  output logic aux_ready,
  input wire logic rxd_pin,
  output icf_pkg::icf_pins_type pins,
  output icf_pkg::icf_status_type status
);
  localparam int BW = $clog2(AUX_W + 3);
  localparam int CW = icf_pkg::CNT_W;

  typedef struct packed {
    logic [1:0] rx_sync;
    icf_pkg::icf_aux_state_type aux_state;
    logic [AUX_W+1:0] aux_shift;
    logic [BW-1:0] aux_bits;
    logic [CW-1:0] aux_cnt;
    logic [CW-1:0] dom_cnt;
    logic [CW-1:0] rearm_cnt;
    logic [CW-1:0] mismatch_cnt;
    icf_pkg::icf_pins_type pins;
    icf_pkg::icf_status_type status;
  } icf_host_state_type;

  icf_host_state_type s_q;
  icf_host_state_type s_d;
  logic [AUX_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_take;

  icf_fifo #(
    .WIDTH(AUX_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_data(aux_data),
    .in_valid(aux_valid),
    .in_ready(aux_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
  );

  // Words leave the FIFO only when idle and no standby request is out.
  assign fifo_take = (s_q.aux_state == icf_pkg::ICF_AUX_IDLE) && !s_q.pins.low_power_request;
  assign can_rx_bit = s_q.rx_sync[1];
  assign pins = s_q.pins;
  assign status = s_q.status;

  always_comb begin
    s_d = s_q;
    s_d.rx_sync = {s_q.rx_sync[0], rxd_pin};
    s_d.pins.low_power_request = standby_req;
    s_d.pins.listen_only = listen_req;

    // Auxiliary serializer: start bit low, data MSB first, stop bit high, one bit per AUX_BIT.
    unique case (s_q.aux_state)
      icf_pkg::ICF_AUX_IDLE: begin
        if (fifo_valid && fifo_take) begin
          s_d.aux_shift = {1'b0, fifo_data, 1'b1};
          s_d.aux_bits = BW'(AUX_W + 2);
          s_d.aux_cnt = '0;
          s_d.aux_state = icf_pkg::ICF_AUX_SEND;
        end
      end
      icf_pkg::ICF_AUX_SEND: begin
        if (!s_q.pins.low_power_request) begin
          if (s_q.aux_cnt == '0) begin
            s_d.pins.aux_pin = s_q.aux_shift[AUX_W+1];
            s_d.aux_shift = {s_q.aux_shift[AUX_W:0], 1'b1};
            s_d.aux_bits = s_q.aux_bits - 1'b1;
          end
          if (s_q.aux_cnt == CW'(AUX_BIT - 1)) begin
            s_d.aux_cnt = '0;
            if (s_q.aux_bits == '0) begin
              s_d.aux_state = icf_pkg::ICF_AUX_IDLE;
            end
          end else begin
            s_d.aux_cnt = s_q.aux_cnt + 1'b1;
          end
        end
      end
    endcase

    // Transmit pin: held recessive in standby and while re-arming after a timeout.
    if (s_q.pins.low_power_request || s_q.status.rearm_active) begin
      s_d.pins.txd = icf_pkg::PIN_RECESSIVE;
    end else begin
      s_d.pins.txd = can_tx_bit;
    end

    if (s_q.pins.txd == icf_pkg::PIN_DOMINANT) begin
      if (s_q.dom_cnt != CW'(DOM_LIMIT)) begin
        s_d.dom_cnt = s_q.dom_cnt + 1'b1;
      end
    end else begin
      s_d.dom_cnt = '0;
    end
    s_d.status.dom_run_long = (s_q.dom_cnt >= CW'(icf_pkg::MAX_DOM_BITS * REARM_CYC));

    if (s_q.status.rearm_active) begin
      if (s_q.rearm_cnt == CW'(REARM_CYC - 1)) begin
        s_d.status.rearm_active = 1'b0;
        s_d.rearm_cnt = '0;
      end else begin
        s_d.rearm_cnt = s_q.rearm_cnt + 1'b1;
      end
    end

    // Driving low while the bus reads recessive means the device driver is off.
    if (!s_q.pins.listen_only && s_q.pins.txd == icf_pkg::PIN_DOMINANT
        && s_q.rx_sync[1] == icf_pkg::PIN_RECESSIVE) begin
      if (s_q.mismatch_cnt != CW'(icf_pkg::LOOP_CYC + 2)) begin
        s_d.mismatch_cnt = s_q.mismatch_cnt + 1'b1;
      end
    end else begin
      s_d.mismatch_cnt = '0;
    end

    if (status_clr) begin
      s_d.status.dom_timeout_seen = 1'b0;
      s_d.status.driver_off_seen = 1'b0;
    end
    if (s_q.mismatch_cnt == CW'(icf_pkg::LOOP_CYC + 2)) begin
      s_d.status.driver_off_seen = 1'b1;
    end
    if (s_q.dom_cnt == CW'(DOM_LIMIT) && !s_q.status.rearm_active) begin
      s_d.status.dom_timeout_seen = 1'b1;
      s_d.status.rearm_active = 1'b1;
      s_d.pins.txd = icf_pkg::PIN_RECESSIVE;
      s_d.rearm_cnt = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.rx_sync <= 2'h3;
      s_q.aux_state <= icf_pkg::ICF_AUX_IDLE;
      s_q.pins.txd <= 1'b1;
      s_q.pins.aux_pin <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : icf_host
`default_nettype wire

// ### rtl/icf_pkg.sv
// Package with constants and carrier types for the isolated CAN fail-safe host controller.
// Functional notes
// - Without a standby request the auxiliary channel carries slow data, sent no faster than 40 kbps.
// - After a dominant timeout the controller drives transmit high to re-arm the transmitter.
// - The controller keeps at least 9600 bps so that 11 dominant bits end before the timeout.
// - Stuffing after five equal bits and six-bit error flags must both fit inside the timeout.
package icf_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int AUX_MAX_BPS = 40_000;
  localparam int AUX_BIT_CYC = (CLK_HZ + AUX_MAX_BPS - 1) / AUX_MAX_BPS;
  localparam int CAN_MIN_BPS = 9600;
  localparam int CAN_MAX_BIT_CYC = CLK_HZ / CAN_MIN_BPS;
  localparam int MAX_DOM_BITS = 11;
  localparam int DOM_LIMIT_US = 1200;
  localparam int DOM_LIMIT_CYC = DOM_LIMIT_US * (CLK_HZ / 1_000_000);
  localparam int LOOP_NS = 200;
  localparam int LOOP_CYC = (LOOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AUX_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W = 16;
  localparam logic PIN_RECESSIVE = 1'b1;
  localparam logic PIN_DOMINANT = 1'b0;

  typedef enum logic [1:0] {
    ICF_AUX_IDLE = 2'b01,
    ICF_AUX_SEND = 2'b10
  } icf_aux_state_type;

  typedef struct packed {
    logic low_power_request;
    logic listen_only;
    logic txd;
    logic aux_pin;
  } icf_pins_type;

  typedef struct packed {
    logic dom_timeout_seen;
    logic driver_off_seen;
    logic rearm_active;
    logic dom_run_long;
  } icf_status_type;

endpackage : icf_pkg
